// *** logic/ppc_params.svh ***
/*
  Constants for the parameter page integrity checker: checksum seed and
  polynomial, offsets inside one 512-byte copy, copy counts.
  Assumes it is included by bare name wherever these constants are used.
*/
`ifndef PPC_PARAMS_SVH
`define PPC_PARAMS_SVH

// checksum engine
`define PPC_CRC_SEED 16'h4F4E
`define PPC_CRC_POLY 16'h8005

// offsets inside one copy
`define PPC_CRC_LAST_OFF 9'h1FD
`define PPC_CHK_LO_OFF 9'h1FE
`define PPC_CHK_HI_OFF 9'h1FF
`define PPC_SIG_BYTES 9'h004

// copy selection
`define PPC_MAND_COPIES 7'h03
`define PPC_SIG_MIN 3'h2

// stream offset counter
`define PPC_OFF_LAST 16'hFFFF
`define PPC_OFF_ONE 16'h0001
`define PPC_OFF_ZERO 16'h0000

`endif

// *** logic/ppc_pkg.sv ***
/*
  Types shared by the parameter page integrity checker.
  Assumes ppc_params.svh holds the numeric constants.
*/
package ppc_pkg;
  typedef enum logic [0:0] {ppc_idle_s, ppc_run_s} ppc_state_t;
endpackage

// *** logic/ppc_crc16_byte.sv ***
/*
  One byte step of the 16-bit parameter page checksum, purely combinational.
  Assumes the caller registers the result and supplies the running value.
*/
`timescale 1ns/1ps
`include "ppc_params.svh"

module ppc_crc16_byte (
  // running checksum and next byte
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data_in,
  // checksum after the byte
  output logic [15:0] crc_out
);

  // bit serial update, msb of the byte first, left shifting register
  function automatic logic [15:0] ppc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    logic fb;
    v = c;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = v[15] ^ d[i];
      v = {v[14:0], 1'b0} ^ (fb ? `PPC_CRC_POLY : 16'h0000);
    end
    return v;
  endfunction

  // no reflection of input or output is applied here
  always_comb begin
    crc_out = ppc_step(crc_in, data_in);
  end

endmodule

// *** logic/ppc_checker.sv ***
/*
  Parameter page integrity checker: follows the byte stream of a parameter
  page read, checks each 512-byte copy against its stored check word and
  reports the first good copy or an integrity error.
  Assumes byte_valid, byte_data, start and stream_end come from logic on clk,
  and sig_word holds the expected page signature, byte 0 in bits 7:0.
*/
// Behaviour
// - the check word is 16 bits in bytes 510-511 of each copy and covers bytes 0 through 509.
// - bytes are fed one at a time from offset 0, each shifted in from bit 7 down to bit 0.
// - the generator is x^16+x^15+x^2+1, feedback constant 8005h in a left shifting register.
// - the checksum register is loaded with 4F4Eh before the first byte of a copy.
// - the register value after byte 509 is the result, with no final mask.
// - neither data bytes nor the result are bit reversed anywhere.
// - bytes 512-1023 repeat bytes 0-511, so offset 512 lines up with offset 0.
// - the second redundant copy at 1024-1535 is used only when the first two copies fail.
// - every redundant copy is stored separately, so each is checked on its own from a fresh seed.
// - further 512-byte copies may follow from offset 1536 with no limit on their number; the checker stops at offset FFFFh, after 128 copies in all.
`timescale 1ns/1ps
`include "ppc_params.svh"

module ppc_checker (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // page read control
  input wire logic start,
  input wire logic stream_end,
  input wire logic [31:0] sig_word,
  // byte stream from the target
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  // results
  output logic busy_r,
  output logic result_done_r,
  output logic sel_valid_r,
  output logic [6:0] sel_copy_r,
  output logic integrity_err_r,
  output logic [15:0] crc_value_r,
  output logic [15:0] chk_word_r
);

  ppc_pkg::ppc_state_t state_r;
  logic [15:0] offs_r;
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;
  logic [7:0] chk_lo_r;
  logic [2:0] sig_hits_r;
  logic [8:0] in_off;
  logic [6:0] copy_idx;
  logic byte_take;
  logic eoc;
  logic match;
  logic extra;
  logic present;
  logic accept;
  logic absent;
  logic finish;

  // pick one signature byte, byte 0 in the low lane
  function automatic logic [7:0] sig_byte(input logic [31:0] w, input logic [1:0] k);
    logic [7:0] b;
    b = w[7:0];
    case (k)
      2'h1: b = w[15:8];
      2'h2: b = w[23:16];
      2'h3: b = w[31:24];
      default: b = w[7:0];
    endcase
    return b;
  endfunction

  // independent byte-wide reference, only the checks below read it
  function automatic logic [15:0] crc_ref(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      v = v[15] ? ({v[14:0], 1'b0} ^ `PPC_CRC_POLY) : {v[14:0], 1'b0};
    end
    return v;
  endfunction

  ppc_crc16_byte u_step (
    .crc_in(crc_r),
    .data_in(byte_data),
    .crc_out(crc_nxt)
  );

  // position inside the stream: low bits are the offset within a copy
  assign in_off = offs_r[8:0];
  assign copy_idx = offs_r[15:9];
  assign byte_take = (state_r == ppc_pkg::ppc_run_s) && byte_valid;
  assign eoc = byte_take && (in_off == `PPC_CHK_HI_OFF);
  // stored word taken as is, low byte at 510, nothing reversed or masked
  assign match = eoc && (crc_r == {byte_data, chk_lo_r});
  assign extra = copy_idx >= `PPC_MAND_COPIES;
  assign present = !extra || (sig_hits_r >= `PPC_SIG_MIN);
  assign accept = match && present;
  // a missing extra copy means nothing more worth checking follows
  assign absent = eoc && extra && (sig_hits_r < `PPC_SIG_MIN);
  assign finish = (state_r == ppc_pkg::ppc_run_s) &&
                  (accept || absent || stream_end || (byte_take && (offs_r == `PPC_OFF_LAST)));

  // read sequencer; a new start always restarts, even mid page
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ppc_pkg::ppc_idle_s;
    end else if (start) begin
      state_r <= ppc_pkg::ppc_run_s;
    end else begin
      case (state_r)
        ppc_pkg::ppc_run_s: begin
          if (finish) begin
            state_r <= ppc_pkg::ppc_idle_s;
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // stream offset; wraps to zero on the byte at the top, which ends the search
  always_ff @(posedge clk) begin
    if (reset || start) begin
      offs_r <= `PPC_OFF_ZERO;
    end else if (byte_take) begin
      offs_r <= offs_r + `PPC_OFF_ONE;
    end
  end

  // checksum register: seeded per copy, frozen over check word byte 510, reloaded with the seed on byte 511
  always_ff @(posedge clk) begin
    if (reset || start) begin
      crc_r <= `PPC_CRC_SEED;
    end else if (byte_take) begin
      if (in_off <= `PPC_CRC_LAST_OFF) begin
        crc_r <= crc_nxt;
      end else if (eoc) begin
        crc_r <= `PPC_CRC_SEED;
      end
    end
  end

  // low half of the stored check word
  always_ff @(posedge clk) begin
    if (reset) begin
      chk_lo_r <= 8'h00;
    end else if (byte_take && (in_off == `PPC_CHK_LO_OFF)) begin
      chk_lo_r <= byte_data;
    end
  end

  // signature hits over the first four bytes of each copy
  always_ff @(posedge clk) begin
    if (reset || start || eoc) begin
      sig_hits_r <= 3'h0;
    end else if (byte_take && (in_off < `PPC_SIG_BYTES) && (byte_data == sig_byte(sig_word, in_off[1:0]))) begin
      sig_hits_r <= sig_hits_r + 3'h1;
    end
  end

  // per copy results, held for software-free readout by the host logic
  always_ff @(posedge clk) begin
    if (reset) begin
      crc_value_r <= 16'h0000;
      chk_word_r <= 16'h0000;
    end else if (eoc) begin
      crc_value_r <= crc_r;
      chk_word_r <= {byte_data, chk_lo_r};
    end
  end

  // verdict; held until the next start, except result_done_r, which pulses for one cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      result_done_r <= 1'b0;
      sel_valid_r <= 1'b0;
      sel_copy_r <= 7'h00;
      integrity_err_r <= 1'b0;
    end else if (start) begin
      busy_r <= 1'b1;
      result_done_r <= 1'b0;
      sel_valid_r <= 1'b0;
      sel_copy_r <= 7'h00;
      integrity_err_r <= 1'b0;
    end else begin
      result_done_r <= finish;
      if (finish) begin
        busy_r <= 1'b0;
        sel_valid_r <= accept;
        sel_copy_r <= copy_idx;
        integrity_err_r <= !accept;
      end
    end
  end

  seed_load_a: assert property (@(posedge clk) disable iff (reset) start |=> crc_r == `PPC_CRC_SEED)
    else $error("checksum not seeded at start");

  crc_step_a: assert property (@(posedge clk) disable iff (reset)
    (byte_take && !start && in_off <= `PPC_CRC_LAST_OFF) |=> crc_r == crc_ref($past(crc_r), $past(byte_data)))
    else $error("checksum step wrong");

  crc_freeze_a: assert property (@(posedge clk) disable iff (reset)
    (byte_take && !start && in_off == `PPC_CHK_LO_OFF) |=> $stable(crc_r))
    else $error("check word byte entered the checksum");

  copy_reseed_a: assert property (@(posedge clk) disable iff (reset)
    (eoc && !start) |=> crc_r == `PPC_CRC_SEED)
    else $error("next copy not reseeded");

  result_direct_a: assert property (@(posedge clk) disable iff (reset)
    (result_done_r && sel_valid_r) |-> crc_value_r == chk_word_r)
    else $error("accepted copy with mismatching word");

  copy_order_a: assert property (@(posedge clk) disable iff (reset)
    (result_done_r && sel_valid_r) |-> sel_copy_r == $past(copy_idx))
    else $error("selected copy index wrong");

  extra_gate_a: assert property (@(posedge clk) disable iff (reset)
    (accept && !start && extra) |-> sig_hits_r >= `PPC_SIG_MIN)
    else $error("extra copy accepted without signature");

  copy_align_a: assert property (@(posedge clk) disable iff (reset)
    (eoc && !start && !finish) |=> in_off == 9'h000 && copy_idx == $past(copy_idx) + 7'h01)
    else $error("copy boundary misaligned");

  done_pulse_a: assert property (@(posedge clk) disable iff (reset)
    result_done_r |-> (sel_valid_r != integrity_err_r) ##1 !result_done_r)
    else $error("verdict pulse malformed");

endmodule

// *** test/ppc_target_model.sv ***
/*
  Flash target model: streams parameter page copies, each with its own
  computed check word, optionally corrupted or with gaps between bytes.
  Assumes the bench drives its controls at the falling edge of clk.
*/
`timescale 1ns/1ps

module ppc_target_model (
  // clock and control
  input wire logic clk,
  input wire logic go,
  input wire logic halt,
  input wire logic gap,
  input wire logic [3:0] ncopies,
  input wire logic [7:0] bad_mask,
  input wire logic [2:0] sig_miss,
  input wire logic [31:0] sig,
  // byte stream
  output logic byte_valid = 1'b0,
  output logic [7:0] byte_data = 8'h00,
  output logic drained = 1'b1
);
  logic go_q = 1'b0;
  logic run = 1'b0;
  logic skip = 1'b0;
  int off = 0;

  // stored content of copy c; extra copies may carry a damaged signature
  function automatic logic [7:0] raw(int c, int k);
    if (k < 4)
      return sig[8*k +: 8] ^ ((c > 2 && k < sig_miss) ? 8'hFF : 8'h00);
    return k[7:0] ^ 8'hA5 ^ {k[8], 7'h00};
  endfunction

  // byte k of copy c; a bad copy is damaged after its check word was made
  function automatic logic [7:0] next_byte(int c, int k);
    logic [15:0] r;
    logic [7:0] b;
    r = 16'h4F4E;
    if (k < 510)
      return raw(c, k) ^ ((k == 100 && bad_mask[c]) ? 8'h01 : 8'h00);
    for (int j = 0; j < 510; j++) begin
      b = raw(c, j);
      for (int i = 7; i >= 0; i--)
        r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? 16'h8005 : 16'h0000);
    end
    return (k == 510) ? r[7:0] : r[15:8];
  endfunction

  always @(posedge clk) go_q <= go;

  // every copy comes from its own stored bytes, never a resend of copy 0
  always @(negedge clk) begin
    if (go_q) begin
      run = 1'b1;
      off = 0;
    end
    if (run && (halt || off >= ncopies * 512))
      run = 1'b0;
    skip = gap & ~skip;
    if (run && !skip) begin
      byte_valid <= 1'b1;
      byte_data <= next_byte(off / 512, off % 512);
      off = off + 1;
    end else begin
      byte_valid <= 1'b0;
      byte_data <= ~byte_data; // released bus shows no stale value
    end
    drained <= !run;
  end
endmodule

// *** test/tb.sv ***
/*
  Self-checking bench for the parameter page integrity checker.
  Assumes the target model streams pages; inputs change at the falling edge.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module tb;
  localparam logic [31:0] SIG = 32'h4D4C4B4A;
  logic clk = 0, reset = 1, start = 0, stream_end = 0, go = 0, gap = 0;
  logic [3:0] ncopies = 4'h0;
  logic [7:0] bad_mask = 8'h00;
  logic [2:0] sig_miss = 3'h0;
  logic byte_valid, drained, busy_r, result_done_r, sel_valid_r, integrity_err_r;
  logic [7:0] byte_data;
  logic [6:0] sel_copy_r;
  logic [15:0] crc_value_r, chk_word_r;
  int miscompares = 0, checks_done = 0, cycles = 0;

  ppc_checker ppc_checker_inst (.clk(clk), .reset(reset), .start(start), .stream_end(stream_end),
    .sig_word(SIG), .byte_valid(byte_valid), .byte_data(byte_data), .busy_r(busy_r),
    .result_done_r(result_done_r), .sel_valid_r(sel_valid_r), .sel_copy_r(sel_copy_r),
    .integrity_err_r(integrity_err_r), .crc_value_r(crc_value_r), .chk_word_r(chk_word_r));

  ppc_target_model tgt (.clk(clk), .go(go), .halt(result_done_r), .gap(gap), .ncopies(ncopies),
    .bad_mask(bad_mask), .sig_miss(sig_miss), .sig(SIG), .byte_valid(byte_valid),
    .byte_data(byte_data), .drained(drained));

  initial forever #50 clk = ~clk;

  // hang guard: far above the sum of all page reads
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one page read; cut ends the transfer once the target runs dry
  task automatic run(input logic [3:0] nc, input logic [7:0] bad, input logic [2:0] miss,
                     input logic g, input logic cut, output int n);
    n = 0;
    @(negedge clk);
    ncopies = nc;
    bad_mask = bad;
    sig_miss = miss;
    gap = g;
    stream_end = 0;
    start = 1;
    go = 1;
    @(negedge clk);
    start = 0;
    go = 0;
    `CHK(busy_r, 1'b1)
    repeat (5000) begin
      @(posedge clk);
      #1 n++;
      if (result_done_r === 1'b1)
        break;
      @(negedge clk);
      stream_end = cut & drained & (n > 2) & ~stream_end;
    end
    `CHK(result_done_r, 1'b1)
    `CHK(busy_r, 1'b0)
  endtask

  task automatic sc_primary_good();
    int n;
    run(4'h3, 8'h00, 3'h0, 1'b0, 1'b0, n);
    `CHK(n, 32'h00000200)
    `CHK(sel_valid_r, 1'b1)
    `CHK(sel_copy_r, 7'h00)
    `CHK(crc_value_r, {tgt.next_byte(0, 511), tgt.next_byte(0, 510)})
    `CHK(chk_word_r, {tgt.next_byte(0, 511), tgt.next_byte(0, 510)})
    @(posedge clk);
    #1 `CHK(result_done_r, 1'b0)
  endtask

  // fallback cases: which copies are damaged and what is chosen
  task automatic sc_fallback(input logic [3:0] nc, input logic [7:0] bad, input logic [2:0] miss,
                             input logic g, input logic cut, input logic ok, input logic [6:0] copy);
    int n;
    run(nc, bad, miss, g, cut, n);
    `CHK(sel_valid_r, ok)
    `CHK(integrity_err_r, ~ok)
    if (ok)
      `CHK(sel_copy_r, copy)
  endtask

  initial begin
    repeat (10) @(negedge clk);
    reset = 0;
    `CHK(busy_r | result_done_r | sel_valid_r | integrity_err_r, 1'b0)
    sc_primary_good();
    sc_fallback(4'h3, 8'h01, 3'h0, 1'b1, 1'b0, 1'b1, 7'h01);
    sc_fallback(4'h3, 8'h03, 3'h0, 1'b0, 1'b0, 1'b1, 7'h02);
    sc_fallback(4'h4, 8'h07, 3'h2, 1'b0, 1'b0, 1'b1, 7'h03);
    sc_fallback(4'h4, 8'h07, 3'h3, 1'b0, 1'b0, 1'b0, 7'h00);
    sc_fallback(4'h3, 8'h07, 3'h0, 1'b1, 1'b1, 1'b0, 7'h00);
    give_verdict();
  end
endmodule
